// ==== design/imv_mask_vector.sv ====
// interrupt mask, software post and vector clear unit
`timescale 1ns/1ns
`default_nettype none

module imv_mask_vector
   import imv_pkg::*;
(
   input  wire logic                 sys_clk,
   input  wire logic                 reset_n,
   input  wire imv_bus_req_t         bus_req,
   output logic [IMV_DW-1:0]         rd_data,
   input  wire logic [IMV_NSRC-1:0]  src_post,
   output logic                      cpu_int_req,
   output logic                      irq
);

   ////////////////////////////////////////////////////////////////////////////
   // address decode

   logic                 wr_mask_ut;
   logic                 wr_mask_pe;
   logic                 wr_soft_en;
   logic                 wr_vec;
   logic                 wr_post_pe;
   logic                 wr_post_ut;
   logic                 wr_evt_clr;
   logic                 wr_evt_en;

   assign wr_mask_ut = bus_req.wr && (bus_req.addr == IMV_OFS_MASK_USB_TIMER);
   assign wr_mask_pe = bus_req.wr && (bus_req.addr == IMV_OFS_MASK_PERIPH);
   assign wr_soft_en = bus_req.wr && (bus_req.addr == IMV_OFS_SOFT_EN);
   assign wr_vec     = bus_req.wr && (bus_req.addr == IMV_OFS_VEC_CLEAR);
   assign wr_post_pe = bus_req.wr && (bus_req.addr == IMV_OFS_POST_PERIPH);
   assign wr_post_ut = bus_req.wr && (bus_req.addr == IMV_OFS_POST_USB_TIMER);
   assign wr_evt_clr = bus_req.wr && (bus_req.addr == IMV_OFS_EVT_CLEAR);
   assign wr_evt_en  = bus_req.wr && (bus_req.addr == IMV_OFS_EVT_ENABLE);

   ////////////////////////////////////////////////////////////////////////////
   // control registers

   logic [IMV_GRP-1:0]   mask_ut_q;
   logic [IMV_GRP-1:0]   mask_pe_q;
   logic                 soft_en_q;
   logic [IMV_NEV-1:0]   evt_en_q;
   logic [IMV_NEV-1:0]   evt_en_d;

   assign evt_en_d = wr_evt_en ? bus_req.wdata[IMV_NEV-1:0] : evt_en_q;

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         mask_ut_q <= IMV_RST_MASK;
         mask_pe_q <= IMV_RST_MASK;
         soft_en_q <= 1'b0;
         evt_en_q  <= IMV_NEV'(IMV_RST_REG);
      end else begin
         if (wr_mask_ut) mask_ut_q <= bus_req.wdata;
         if (wr_mask_pe) mask_pe_q <= bus_req.wdata;
         // upper bits are not stored, so a careless write cannot enable anything
         if (wr_soft_en) soft_en_q <= bus_req.wdata[IMV_SOFT_EN_BIT];
         evt_en_q  <= evt_en_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // posted flags and pending state

   logic [IMV_NSRC-1:0]  mask_all;
   logic [IMV_NSRC-1:0]  post_sel;
   logic [IMV_NSRC-1:0]  post_data;
   logic [IMV_NSRC-1:0]  sw_post;
   logic [IMV_NSRC-1:0]  sw_clr;
   logic [IMV_NSRC-1:0]  posted_d;
   logic [IMV_NSRC-1:0]  posted_q;
   logic [IMV_NSRC-1:0]  pend;

   assign mask_all  = {mask_ut_q, mask_pe_q};
   assign post_sel  = {{IMV_GRP{wr_post_ut}}, {IMV_GRP{wr_post_pe}}};
   assign post_data = {bus_req.wdata, bus_req.wdata};
   assign sw_post   = post_sel & post_data & {IMV_NSRC{soft_en_q}};
   assign sw_clr    = post_sel & ~post_data & {IMV_NSRC{~soft_en_q}};

   // a post in the same cycle as any clear wins, so no event is dropped
   for (genvar i = 0; i < IMV_NSRC; i++) begin : g_src
      assign posted_d[i] = (src_post[i] || sw_post[i]) ? 1'b1 :
                           (wr_vec || sw_clr[i])       ? 1'b0 :
                           posted_q[i];
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         posted_q <= '0;
      end else begin
         posted_q <= posted_d;
      end
   end

   // kept combinational so a vector flush empties pending with the posted flags
   assign pend = posted_q & mask_all;

   ////////////////////////////////////////////////////////////////////////////
   // vector

   logic                 pend_valid;
   logic [IMV_IDXW-1:0]  pend_idx;
   logic [IMV_DW-1:0]    vec_code;

   imv_prio_enc #(
      .N  (IMV_NSRC),
      .IW (IMV_IDXW)
   ) u_prio (
      .req   (pend),
      .valid (pend_valid),
      .idx   (pend_idx)
   );

   assign vec_code = pend_valid ?
                     IMV_DW'((IMV_DW'(pend_idx) + IMV_DW'(1)) * IMV_VEC_STEP) :
                     IMV_VEC_NONE;

   ////////////////////////////////////////////////////////////////////////////
   // events and interrupt output

   logic [IMV_NSRC-1:0]  pend_prev_q;
   logic [IMV_NEV-1:0]   evt_set;
   logic [IMV_NEV-1:0]   evt_clr;
   logic [IMV_NEV-1:0]   evt_status_q;
   logic [IMV_NEV-1:0]   evt_status_d;

   assign evt_set[IMV_EV_NEW_PEND]  = |(pend & ~pend_prev_q);
   assign evt_set[IMV_EV_FLUSH]     = wr_vec;
   assign evt_set[IMV_EV_SOFT_POST] = |sw_post;
   assign evt_clr = wr_evt_clr ? bus_req.wdata[IMV_NEV-1:0] : '0;
   // a set in the same cycle as its clear wins
   assign evt_status_d = (evt_status_q & ~evt_clr) | evt_set;

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         pend_prev_q  <= '0;
         evt_status_q <= '0;
         irq          <= 1'b0;
         cpu_int_req  <= 1'b0;
      end else begin
         pend_prev_q  <= pend;
         evt_status_q <= evt_status_d;
         // built from next-state values so irq tracks the enabled status with no lag
         irq          <= |(evt_status_d & evt_en_d);
         cpu_int_req  <= pend_valid;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read path: data valid only in the cycle after the read strobe

   logic [IMV_DW-1:0]    rd_mux;

   assign rd_mux =
      (bus_req.addr == IMV_OFS_MASK_USB_TIMER) ? mask_ut_q :
      (bus_req.addr == IMV_OFS_MASK_PERIPH)    ? mask_pe_q :
      (bus_req.addr == IMV_OFS_SOFT_EN)        ? IMV_DW'(soft_en_q) :
      (bus_req.addr == IMV_OFS_VEC_CLEAR)      ? vec_code :
      (bus_req.addr == IMV_OFS_POST_PERIPH)    ? posted_q[IMV_GRP-1:0] :
      (bus_req.addr == IMV_OFS_POST_USB_TIMER) ? posted_q[IMV_NSRC-1:IMV_GRP] :
      (bus_req.addr == IMV_OFS_EVT_STATUS)     ? IMV_DW'(evt_status_q) :
      (bus_req.addr == IMV_OFS_EVT_ENABLE)     ? IMV_DW'(evt_en_q) :
      IMV_RD_UNMAPPED;

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         rd_data <= IMV_RD_IDLE;
      end else begin
         rd_data <= bus_req.rd ? rd_mux : IMV_RD_IDLE;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // assertions

   sequence s_mask_ut_write;
      wr_mask_ut;
   endsequence

   sequence s_mask_ut_read;
      bus_req.rd && (bus_req.addr == IMV_OFS_MASK_USB_TIMER);
   endsequence

   property p_masked_post_kept;
      @(posedge sys_clk) disable iff (!reset_n)
      (|(src_post & ~mask_all)) |=> ((posted_q & $past(src_post)) == $past(src_post));
   endproperty
   a_masked_post_kept: assert property (p_masked_post_kept)
      else $error("masked source lost its posted interrupt");

   property p_mask_blocks_pending;
      @(posedge sys_clk) disable iff (!reset_n)
      (wr_mask_ut && (bus_req.wdata == 8'h00)) |=> (pend[IMV_NSRC-1:IMV_GRP] == 8'h00)
         && (cpu_int_req == 1'b0 || (|pend[IMV_GRP-1:0]) || $past(pend_valid));
   endproperty
   a_mask_blocks_pending: assert property (p_mask_blocks_pending)
      else $error("cleared mask bit still lets source become pending");

   property p_mask_ut_readback;
      @(posedge sys_clk) disable iff (!reset_n)
      (s_mask_ut_write ##1 s_mask_ut_read) |=> (rd_data == $past(bus_req.wdata, 2));
   endproperty
   a_mask_ut_readback: assert property (p_mask_ut_readback)
      else $error("usb/timer mask readback differs from written value");

   property p_i2c_pending;
      @(posedge sys_clk) disable iff (!reset_n)
      (mask_pe_q[IMV_B_I2C] && src_post[IMV_B_I2C] && !wr_mask_pe) |=> pend[IMV_B_I2C];
   endproperty
   a_i2c_pending: assert property (p_i2c_pending)
      else $error("unmasked i2c post did not become pending");

   property p_soft_en_read;
      @(posedge sys_clk) disable iff (!reset_n)
      (bus_req.rd && (bus_req.addr == IMV_OFS_SOFT_EN))
         |=> (rd_data == {7'h00, $past(soft_en_q)});
   endproperty
   a_soft_en_read: assert property (p_soft_en_read)
      else $error("soft enable register reads wrong value");

   property p_vector_read;
      @(posedge sys_clk) disable iff (!reset_n)
      (bus_req.rd && (bus_req.addr == IMV_OFS_VEC_CLEAR) && pend[0])
         |=> (rd_data == IMV_VEC_STEP);
   endproperty
   a_vector_read: assert property (p_vector_read)
      else $error("vector read does not report the top pending source");

   property p_vector_flush;
      @(posedge sys_clk) disable iff (!reset_n)
      (wr_vec && (src_post == '0)) |=> (posted_q == '0) ##0 (pend == '0) ##1 !cpu_int_req;
   endproperty
   a_vector_flush: assert property (p_vector_flush)
      else $error("vector write left posted or pending state behind");

   property p_soft_post;
      @(posedge sys_clk) disable iff (!reset_n)
      (wr_post_pe && soft_en_q)
         |=> ((posted_q[IMV_GRP-1:0] & $past(bus_req.wdata)) == $past(bus_req.wdata));
   endproperty
   a_soft_post: assert property (p_soft_post)
      else $error("software post did not set posted flag");

   property p_soft_clear;
      @(posedge sys_clk) disable iff (!reset_n)
      (wr_post_pe && !soft_en_q && (src_post == '0))
         |=> (posted_q[IMV_GRP-1:0] == ($past(posted_q[IMV_GRP-1:0]) & $past(bus_req.wdata)));
   endproperty
   a_soft_clear: assert property (p_soft_clear)
      else $error("posted/clear write with soft enable off misbehaved");

   property p_pending_request;
      @(posedge sys_clk) disable iff (!reset_n)
      (|(posted_q & mask_all)) |=> cpu_int_req;
   endproperty
   a_pending_request: assert property (p_pending_request)
      else $error("pending source did not raise the core request");

   property p_irq_level;
      @(posedge sys_clk) disable iff (!reset_n)
      1'b1 |-> (irq == (|(evt_status_q & evt_en_q)));
   endproperty
   a_irq_level: assert property (p_irq_level)
      else $error("interrupt output does not follow enabled status");

   property p_vector_none;
      @(posedge sys_clk) disable iff (!reset_n)
      (bus_req.rd && (bus_req.addr == IMV_OFS_VEC_CLEAR) && (pend == '0))
         |=> (rd_data == IMV_VEC_NONE);
   endproperty
   a_vector_none: assert property (p_vector_none)
      else $error("vector read with nothing pending is not zero");

   property p_soft_post_exact;
      @(posedge sys_clk) disable iff (!reset_n)
      (wr_post_pe && soft_en_q && (src_post == '0))
         |=> (posted_q[IMV_GRP-1:0] == ($past(posted_q[IMV_GRP-1:0]) | $past(bus_req.wdata)));
   endproperty
   a_soft_post_exact: assert property (p_soft_post_exact)
      else $error("software post write with enable on cleared a posted flag");

   property p_no_pend_no_req;
      @(posedge sys_clk) disable iff (!reset_n)
      (pend == '0) |=> !cpu_int_req;
   endproperty
   a_no_pend_no_req: assert property (p_no_pend_no_req)
      else $error("core request raised with no unmasked posted source");

   property p_soft_en_hold;
      @(posedge sys_clk) disable iff (!reset_n)
      !wr_soft_en |=> $stable(soft_en_q);
   endproperty
   a_soft_en_hold: assert property (p_soft_en_hold)
      else $error("soft enable changed without a write");

endmodule : imv_mask_vector
`default_nettype wire

// ==== design/imv_prio_enc.sv ====
// priority encoder: lowest set request index wins
`timescale 1ns/1ns
`default_nettype none

module imv_prio_enc #(
   parameter int unsigned N  = 16,
   parameter int unsigned IW = 4
) (
   input  wire logic [N-1:0]  req,
   output logic               valid,
   output logic [IW-1:0]      idx
);

   if (N < 1 || (1 << IW) < N) begin : g_chk
      $error("imv_prio_enc: index width too small for request count");
   end

   assign valid = |req;

   // scan downward so the lowest index is the last to assign
   always_comb begin
      idx = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (req[i]) begin
            idx = IW'(i);
         end
      end
   end

endmodule : imv_prio_enc
`default_nettype wire

// ==== include/imv_pkg.sv ====
// constants, field layout and bus carrier for the interrupt mask and vector unit
package imv_pkg;

   localparam int unsigned IMV_DW      = 8;
   localparam int unsigned IMV_AW      = 8;
   localparam int unsigned IMV_GRP     = 8;
   localparam int unsigned IMV_NSRC    = 16;
   localparam int unsigned IMV_IDXW    = 4;
   localparam int unsigned IMV_NEV     = 3;

   // register byte offsets
   localparam logic [7:0] IMV_OFS_MASK_USB_TIMER = 8'hDF;
   localparam logic [7:0] IMV_OFS_MASK_PERIPH    = 8'hE0;
   localparam logic [7:0] IMV_OFS_SOFT_EN        = 8'hE1;
   localparam logic [7:0] IMV_OFS_VEC_CLEAR      = 8'hE2;
   localparam logic [7:0] IMV_OFS_POST_PERIPH    = 8'hD0;
   localparam logic [7:0] IMV_OFS_POST_USB_TIMER = 8'hD1;
   localparam logic [7:0] IMV_OFS_EVT_STATUS     = 8'hE8;
   localparam logic [7:0] IMV_OFS_EVT_CLEAR      = 8'hE9;
   localparam logic [7:0] IMV_OFS_EVT_ENABLE     = 8'hEA;

   // reset values and unmapped read data
   localparam logic [7:0] IMV_RST_MASK    = 8'h00;
   localparam logic [7:0] IMV_RST_REG     = 8'h00;
   localparam logic [7:0] IMV_RD_IDLE     = 8'h00;
   localparam logic [7:0] IMV_RD_UNMAPPED = 8'h00;

   // peripheral group: source index = bit of int_mask_peripheral
   localparam int unsigned IMV_B_VMON     = 0;
   localparam int unsigned IMV_B_ANALOG   = 1;
   localparam int unsigned IMV_B_TOUCH    = 2;   // touch_sense_source
   localparam int unsigned IMV_B_TIMER0   = 3;
   localparam int unsigned IMV_B_GPIO     = 4;
   localparam int unsigned IMV_B_SPI      = 5;
   localparam int unsigned IMV_B_SLEEP    = 6;
   localparam int unsigned IMV_B_I2C      = 7;
   // usb/timer group: source index = IMV_GRP + bit of int_mask_usb_timer
   localparam int unsigned IMV_B_TIMER1   = 0;
   localparam int unsigned IMV_B_TIMER2   = 1;
   localparam int unsigned IMV_B_USB_RST  = 2;
   localparam int unsigned IMV_B_USB_SOF  = 3;
   localparam int unsigned IMV_B_USB_EP0  = 4;   // usb_ep_zero_source, ep1..ep3 follow

   localparam int unsigned IMV_SOFT_EN_BIT = 0;

   // vector codes: (source index + 1) * step, none pending reads as zero
   localparam logic [7:0] IMV_VEC_STEP = 8'h04;
   localparam logic [7:0] IMV_VEC_NONE = 8'h00;

   // event status bits
   localparam int unsigned IMV_EV_NEW_PEND  = 0;
   localparam int unsigned IMV_EV_FLUSH     = 1;
   localparam int unsigned IMV_EV_SOFT_POST = 2;

   typedef struct packed {
      logic [IMV_AW-1:0] addr;
      logic [IMV_DW-1:0] wdata;
      logic              wr;
      logic              rd;
   } imv_bus_req_t;

endpackage : imv_pkg

// ==== test/imv_mask_vector_tb.sv ====
// self-checking bench for the interrupt mask and vector unit
`timescale 1ns/1ns
`default_nettype none

module imv_mask_vector_tb;
   import imv_pkg::*;

   logic                 sys_clk;
   logic                 reset_n;
   imv_bus_req_t         bus_req;
   logic [IMV_DW-1:0]    rd_data;
   logic [IMV_NSRC-1:0]  src_post;
   logic                 cpu_int_req;
   logic                 irq;
   logic                 fire;
   logic [IMV_IDXW-1:0]  fire_idx;
   int                   errors;
   int                   compares;

   imv_mask_vector u_imv_mask_vector (.sys_clk(sys_clk), .reset_n(reset_n), .bus_req(bus_req),
      .rd_data(rd_data), .src_post(src_post), .cpu_int_req(cpu_int_req), .irq(irq));
   imv_src_model u_imv_src_model (.sys_clk(sys_clk), .reset_n(reset_n), .fire(fire),
      .fire_idx(fire_idx), .src_post(src_post));

   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk8

   task automatic chk1(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk1

   // one idle cycle between accesses keeps every strobe a clean single pulse
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      bus_req <= '0;
   endtask : wr

   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk);
      bus_req <= '0;
      #1;
      chk8(rd_data, exp);
   endtask : rchk

   // write then read back with no idle cycle between, as the bus allows
   task automatic wrchk(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
      @(posedge sys_clk);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk);
      bus_req <= '0;
      #1;
      chk8(rd_data, exp);
   endtask : wrchk

   task automatic post(input int idx);
      @(posedge sys_clk);
      fire     <= 1'b1;
      fire_idx <= IMV_IDXW'(idx);
      @(posedge sys_clk);
      fire     <= 1'b0;
      repeat (3) @(posedge sys_clk);
   endtask : post

   task automatic test_done;
      $display("compares=%0d errors=%0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : test_done

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5000) @(posedge sys_clk);
      errors++;
      test_done;
   end

   initial begin
      logic [7:0] ma;
      logic [7:0] regs [4];
      regs = '{IMV_OFS_MASK_USB_TIMER, IMV_OFS_MASK_PERIPH, IMV_OFS_SOFT_EN, IMV_OFS_VEC_CLEAR};
      errors   = 0;
      compares = 0;
      reset_n  = 1'b0;
      bus_req  = '0;
      fire     = 1'b0;
      fire_idx = '0;
      repeat (10) @(posedge sys_clk);
      reset_n <= 1'b1;
      foreach (regs[k]) rchk(regs[k], 8'h00);
      rchk(8'h10, IMV_RD_UNMAPPED);
      chk1(cpu_int_req, 1'b0);
      // walk every source through its own mask bit, then flush
      for (int i = 0; i < 16; i++) begin
         ma = (i < 8) ? IMV_OFS_MASK_PERIPH : IMV_OFS_MASK_USB_TIMER;
         wrchk(ma, 8'(1 << (i % 8)), 8'(1 << (i % 8)));
         post(i);
         rchk(IMV_OFS_VEC_CLEAR, 8'((i + 1) * 4));
         chk1(cpu_int_req, 1'b1);
         wr(IMV_OFS_VEC_CLEAR, 8'h5A);
         rchk(IMV_OFS_VEC_CLEAR, 8'h00);
         rchk(IMV_OFS_POST_PERIPH, 8'h00);
         rchk(IMV_OFS_POST_USB_TIMER, 8'h00);
         chk1(cpu_int_req, 1'b0);
         wr(ma, 8'h00);
      end
      // masked sources keep posting; unmasking promotes them
      post(5);
      post(12);
      rchk(IMV_OFS_POST_PERIPH, 8'h20);
      rchk(IMV_OFS_POST_USB_TIMER, 8'h10);
      rchk(IMV_OFS_VEC_CLEAR, 8'h00);
      chk1(cpu_int_req, 1'b0);
      wr(IMV_OFS_MASK_PERIPH, 8'h20);
      wr(IMV_OFS_MASK_USB_TIMER, 8'h10);
      rchk(IMV_OFS_VEC_CLEAR, 8'h18);
      wr(IMV_OFS_MASK_PERIPH, 8'h00);
      rchk(IMV_OFS_VEC_CLEAR, 8'h34);
      wr(IMV_OFS_VEC_CLEAR, 8'h00);
      rchk(IMV_OFS_POST_USB_TIMER, 8'h00);
      wr(IMV_OFS_MASK_USB_TIMER, 8'h00);
      // software posting and clearing under both settings of the enable
      wr(IMV_OFS_POST_PERIPH, 8'hFF);
      rchk(IMV_OFS_POST_PERIPH, 8'h00);
      wr(IMV_OFS_SOFT_EN, 8'h01);
      rchk(IMV_OFS_SOFT_EN, 8'h01);
      wr(IMV_OFS_POST_PERIPH, 8'h81);
      rchk(IMV_OFS_POST_PERIPH, 8'h81);
      wr(IMV_OFS_POST_PERIPH, 8'h00);
      rchk(IMV_OFS_POST_PERIPH, 8'h81);
      wr(IMV_OFS_SOFT_EN, 8'h00);
      wr(IMV_OFS_POST_PERIPH, 8'h7F);
      rchk(IMV_OFS_POST_PERIPH, 8'h01);
      wr(IMV_OFS_POST_PERIPH, 8'hFE);
      rchk(IMV_OFS_POST_PERIPH, 8'h00);
      // event status, enable, clear and the interrupt line
      rchk(IMV_OFS_EVT_STATUS, 8'h07);
      chk1(irq, 1'b0);
      wr(IMV_OFS_EVT_CLEAR, 8'h07);
      rchk(IMV_OFS_EVT_STATUS, 8'h00);
      wr(IMV_OFS_EVT_ENABLE, 8'h01);
      wr(IMV_OFS_MASK_PERIPH, 8'h01);
      post(0);
      rchk(IMV_OFS_EVT_STATUS, 8'h01);
      chk1(irq, 1'b1);
      wr(IMV_OFS_EVT_ENABLE, 8'h00);
      rchk(IMV_OFS_EVT_ENABLE, 8'h00);
      chk1(irq, 1'b0);
      wr(IMV_OFS_EVT_ENABLE, 8'h01);
      wr(IMV_OFS_EVT_CLEAR, 8'h01);
      rchk(IMV_OFS_EVT_STATUS, 8'h00);
      chk1(irq, 1'b0);
      rchk(IMV_OFS_EVT_CLEAR, 8'h00);
      wr(IMV_OFS_VEC_CLEAR, 8'h00);
      rchk(IMV_OFS_EVT_STATUS, 8'h02);
      test_done;
   end

endmodule : imv_mask_vector_tb

`default_nettype wire

// ==== test/imv_src_model.sv ====
// model of the peripheral interrupt sources: one-cycle post pulses on request
`timescale 1ns/1ns
`default_nettype none

module imv_src_model
   import imv_pkg::*;
(
   input  wire logic                 sys_clk,
   input  wire logic                 reset_n,
   input  wire logic                 fire,
   input  wire logic [IMV_IDXW-1:0]  fire_idx,
   output logic [IMV_NSRC-1:0]       src_post
);

   // a source posts regardless of its mask; masking is the controller's business
   always_ff @(posedge sys_clk) begin
      if (!reset_n)
         src_post <= '0;
      else if (fire)
         src_post <= IMV_NSRC'(1) << fire_idx;
      else
         src_post <= '0;
   end

endmodule : imv_src_model

`default_nettype wire
